/* File: include/bcd_clock_pkg.sv */
// constants, carriers and helpers for the bcd calendar clock register block
// assumes a single 250 mhz system clock and an axi4-lite master on the register side
package bcd_clock_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned TICK_W = 28;

	// system clock and the one-second period derived from it
	localparam int unsigned CLK_HZ = 250000000;
	localparam int unsigned SECOND_PERIOD_S = 1;
	localparam int unsigned SECOND_CYCLES_DEFAULT = CLK_HZ * SECOND_PERIOD_S;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_HOUR_FORMAT_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TIME_OF_DAY = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CALENDAR_DATE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_TIME_ALARM = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_DATE_ALARM = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATUS_CLEAR = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_ENTRY_VALIDITY = 8'h2c;

	// field positions
	localparam int unsigned CR_TIME_REQ = 0;
	localparam int unsigned CR_CAL_REQ = 1;
	localparam int unsigned CR_TIME_SEL_LSB = 8;
	localparam int unsigned CR_CAL_SEL_LSB = 16;
	localparam int unsigned MR_HOUR_FORMAT = 0;
	localparam int unsigned TM_SECONDS_LSB = 0;
	localparam int unsigned TM_MINUTES_LSB = 8;
	localparam int unsigned TM_HOURS_LSB = 16;
	localparam int unsigned TM_MERIDIEM = 22;
	localparam int unsigned CD_CENTURY_LSB = 0;
	localparam int unsigned CD_YEAR_LSB = 8;
	localparam int unsigned CD_MONTH_LSB = 16;
	localparam int unsigned CD_WEEKDAY_LSB = 21;
	localparam int unsigned CD_DATE_LSB = 24;
	localparam int unsigned ST_UPDATE_ACK = 0;
	localparam int unsigned ST_SECOND_EVENT = 2;
	localparam int unsigned ST_TIME_EVENT = 3;
	localparam int unsigned ST_CAL_EVENT = 4;
	localparam int unsigned VER_TIME = 0;
	localparam int unsigned VER_CAL = 1;

	// writable bit masks; everything else reads zero
	localparam logic [31:0] CR_MASK = 32'h00030303;
	localparam logic [31:0] MR_MASK = 32'h00000001;
	localparam logic [31:0] TIME_ALARM_MASK = 32'h00ffffff;
	localparam logic [31:0] DATE_ALARM_MASK = 32'hbf9f0000;

	// reset values
	localparam logic [31:0] CAL_RESET = 32'h01210720;
	localparam logic [31:0] DATE_ALARM_RESET = 32'h01010000;

	// counter limits (binary, except the bcd century)
	localparam logic [5:0] SECONDS_MAX = 6'd59;
	localparam logic [4:0] HOURS24_MAX = 5'd23;
	localparam logic [4:0] HOURS12_MAX = 5'd12;
	localparam logic [4:0] NOON_HOUR = 5'd12;
	localparam logic [2:0] WEEKDAY_MAX = 3'd7;
	localparam logic [2:0] MONDAY = 3'd1;
	localparam logic [3:0] MONTH_MAX = 4'd12;
	localparam logic [6:0] YEAR_MAX = 7'd99;
	localparam logic [7:0] CENTURY_ONLY_BCD = 8'h20;
	localparam logic [4:0] DATE_LONG = 5'd31;
	localparam logic [4:0] DATE_SHORT = 5'd30;
	localparam logic [4:0] FEB_LEAP = 5'd29;
	localparam logic [4:0] FEB_PLAIN = 5'd28;
	localparam logic [3:0] FEBRUARY = 4'd2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		TEV_MINUTE = 2'h0,
		TEV_HOUR = 2'h1,
		TEV_MIDNIGHT = 2'h2,
		TEV_NOON = 2'h3
	} time_event_sel_e;

	typedef enum logic [1:0] {
		CEV_WEEK = 2'h0,
		CEV_MONTH = 2'h1,
		CEV_YEAR = 2'h2
	} cal_event_sel_e;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_s;

	function automatic logic [6:0] fromBcd(input logic [7:0] b);
		return 7'({3'h0, b[7:4]} * 7'd10) + 7'({3'h0, b[3:0]});
	endfunction : fromBcd

	function automatic logic [7:0] toBcd(input logic [6:0] v);
		logic [6:0] hi;
		logic [6:0] lo;
		hi = v / 7'd10;
		lo = v % 7'd10;
		return {hi[3:0], lo[3:0]};
	endfunction : toBcd

	function automatic logic bcdOk(input logic [7:0] b);
		return (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9);
	endfunction : bcdOk

endpackage : bcd_clock_pkg

/* File: src/bcd_calendar_clock_regs.sv */
// register block and counters of a bcd time-of-day and calendar clock
// assumes an axi4-lite master on clk_sys and a same-clock write-protect level
//
// Notes on behaviour
// - control and mode writes are dropped while write protection is on.
// - time request bit 0 set stops seconds, minutes and hours.
// - time or calendar loads only after matching request set and acknowledged.
// - calendar request bit 1 set stops day, date, month, year, century.
// - clearing a set request ends the update; writing zero otherwise does nothing.
// - time event select: minute, hour, midnight or noon sets the time event.
// - calendar event select: monday midnight, first of month, or january first.
// - mode bit 0 picks 24-hour (0) or 12-hour with meridiem (1).
// - seconds and minutes accept bcd 0 through 59 only.
// - bcd fields carry units in low four bits, tens above.
// - hours accept 1-12 in 12-hour mode, 0-23 in 24-hour mode.
// - time bit 22 is the meridiem bit in 12-hour mode, 1 means afternoon.
// - century accepts only bcd 20 on write.
// - year accepts bcd 00 through 99.
// - month accepts bcd 01 through 12.
// - update acknowledge rises within one second of a request.
// - an invalid time or date write loads nothing and flags validity.
// - time request halts time and calendar; calendar request halts calendar only.
// - a 12-hour write reads back as the 24-hour value.
`timescale 1ns/1ps
`default_nettype none

module bcd_calendar_clock_regs import bcd_clock_pkg::*; #(
	parameter int unsigned SECOND_CYCLES = SECOND_CYCLES_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic writeProtectEnable,
	input wire axi_req_s axiReq,
	output var axi_rsp_s axiRsp
);

	typedef struct packed {
		logic awHeld;
		logic [ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [TICK_W-1:0] tickCnt;
		logic timeUpdateRequest;
		logic calendarUpdateRequest;
		logic updateGranted;
		time_event_sel_e timeEventSelect;
		cal_event_sel_e calendarEventSelect;
		logic hourFormatSelect;
		logic [5:0] seconds;
		logic [5:0] minutes;
		logic [4:0] hours;
		logic [2:0] weekday;
		logic [4:0] date;
		logic [3:0] month;
		logic [6:0] year;
		logic [31:0] timeAlarm;
		logic [31:0] dateAlarm;
		logic [4:0] status;
		logic [4:0] irqMask;
		logic [1:0] validity;
	} clock_state_s;

	clock_state_s st_reg;
	clock_state_s st_next;

	logic tick;
	logic secWrap;
	logic minWrap;
	logic hourWrap;
	logic calRun;
	logic dateWrap;
	logic monthWrap;
	logic timeEvt;
	logic calEvt;
	logic [4:0] setBits;
	logic [4:0] clrBits;
	logic [31:0] strobeMask;
	logic [32:0] wrBack;
	logic [31:0] wd;
	logic [32:0] rdBack;
	logic wrProtected;
	logic timeOk;
	logic calOk;
	logic [6:0] wSec;
	logic [6:0] wMin;
	logic [6:0] wHour;
	logic [6:0] wHour24;
	logic [6:0] wYear;
	logic [6:0] wMonth;
	logic [6:0] wDate;
	logic [2:0] wWeekday;

	function automatic logic [4:0] daysIn(input logic [3:0] m, input logic [6:0] y);
		// century is pinned to 20, so every year divisible by four is leap
		if (m == FEBRUARY) begin
			return (y[1:0] == 2'b00) ? FEB_LEAP : FEB_PLAIN;
		end
		if ((m == 4'd4) || (m == 4'd6) || (m == 4'd9) || (m == 4'd11)) begin
			return DATE_SHORT;
		end
		return DATE_LONG;
	endfunction : daysIn

	// readback of one word; top bit marks a mapped offset
	function automatic logic [32:0] readBack(input clock_state_s s, input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		logic [31:0] d;
		logic hit;
		logic [7:0] b;
		w = {a[ADDR_W-1:2], 2'b00};
		d = '0;
		hit = 1'b1;
		if (w == OFF_CLOCK_CONTROL) begin
			d[CR_TIME_REQ] = s.timeUpdateRequest;
			d[CR_CAL_REQ] = s.calendarUpdateRequest;
			d[CR_TIME_SEL_LSB +: 2] = s.timeEventSelect;
			d[CR_CAL_SEL_LSB +: 2] = s.calendarEventSelect;
		end else if (w == OFF_HOUR_FORMAT_MODE) begin
			d[MR_HOUR_FORMAT] = s.hourFormatSelect;
		end else if (w == OFF_TIME_OF_DAY) begin
			// hours always read in 24-hour form
			b = toBcd({1'b0, s.seconds});
			d[TM_SECONDS_LSB +: 7] = b[6:0];
			b = toBcd({1'b0, s.minutes});
			d[TM_MINUTES_LSB +: 7] = b[6:0];
			b = toBcd({2'b00, s.hours});
			d[TM_HOURS_LSB +: 6] = b[5:0];
		end else if (w == OFF_CALENDAR_DATE) begin
			d[CD_CENTURY_LSB +: 7] = CENTURY_ONLY_BCD[6:0];
			d[CD_YEAR_LSB +: 8] = toBcd(s.year);
			b = toBcd({3'b000, s.month});
			d[CD_MONTH_LSB +: 5] = b[4:0];
			d[CD_WEEKDAY_LSB +: 3] = s.weekday;
			b = toBcd({2'b00, s.date});
			d[CD_DATE_LSB +: 6] = b[5:0];
		end else if (w == OFF_TIME_ALARM) begin
			d = s.timeAlarm;
		end else if (w == OFF_DATE_ALARM) begin
			d = s.dateAlarm;
		end else if (w == OFF_EVENT_STATUS) begin
			d[4:0] = s.status;
		end else if (w == OFF_IRQ_MASK) begin
			d[4:0] = s.irqMask;
		end else if (w == OFF_ENTRY_VALIDITY) begin
			d[1:0] = s.validity;
		end else if ((w == OFF_STATUS_CLEAR) || (w == OFF_IRQ_ENABLE_SET)
				|| (w == OFF_IRQ_ENABLE_CLEAR)) begin
			d = '0;
		end else begin
			hit = 1'b0;
		end
		return {hit, d};
	endfunction : readBack

	always_comb begin
		axiRsp.awready = !st_reg.awHeld && !st_reg.bValid;
		axiRsp.wready = !st_reg.wHeld && !st_reg.bValid;
		axiRsp.bvalid = st_reg.bValid;
		axiRsp.bresp = st_reg.bResp;
		axiRsp.arready = !st_reg.rValid;
		axiRsp.rvalid = st_reg.rValid;
		axiRsp.rdata = st_reg.rData;
		axiRsp.rresp = st_reg.rResp;
	end

	always_comb begin
		st_next = st_reg;
		setBits = '0;
		clrBits = '0;
		secWrap = 1'b0;
		minWrap = 1'b0;
		hourWrap = 1'b0;
		calRun = 1'b0;
		dateWrap = 1'b0;
		monthWrap = 1'b0;
		timeEvt = 1'b0;
		calEvt = 1'b0;

		// one-second enable from the system clock
		tick = st_reg.tickCnt == TICK_W'(SECOND_CYCLES - 1);
		st_next.tickCnt = tick ? '0 : st_reg.tickCnt + 1'b1;
		setBits[ST_SECOND_EVENT] = tick;

		// time counters stop while the time request is up
		if (tick && !st_reg.timeUpdateRequest) begin
			secWrap = st_reg.seconds == SECONDS_MAX;
			st_next.seconds = secWrap ? '0 : st_reg.seconds + 1'b1;
			if (secWrap) begin
				minWrap = st_reg.minutes == SECONDS_MAX;
				st_next.minutes = minWrap ? '0 : st_reg.minutes + 1'b1;
				if (minWrap) begin
					hourWrap = st_reg.hours == HOURS24_MAX;
					st_next.hours = hourWrap ? '0 : st_reg.hours + 1'b1;
				end
			end
		end

		case (st_reg.timeEventSelect)
			TEV_MINUTE: begin
				timeEvt = secWrap;
			end
			TEV_HOUR: begin
				timeEvt = minWrap;
			end
			TEV_MIDNIGHT: begin
				timeEvt = hourWrap;
			end
			default: begin
				timeEvt = minWrap && (st_next.hours == NOON_HOUR);
			end
		endcase

		// calendar sits downstream of the hour carry, so a time request stops it too
		calRun = hourWrap && !st_reg.calendarUpdateRequest;
		if (calRun) begin
			st_next.weekday = (st_reg.weekday == WEEKDAY_MAX) ? MONDAY : st_reg.weekday + 1'b1;
			dateWrap = st_reg.date == daysIn(st_reg.month, st_reg.year);
			st_next.date = dateWrap ? 5'd1 : st_reg.date + 1'b1;
			if (dateWrap) begin
				monthWrap = st_reg.month == MONTH_MAX;
				st_next.month = monthWrap ? 4'd1 : st_reg.month + 1'b1;
				if (monthWrap) begin
					st_next.year = (st_reg.year == YEAR_MAX) ? '0 : st_reg.year + 1'b1;
				end
			end
		end

		case (st_reg.calendarEventSelect)
			CEV_WEEK: begin
				calEvt = calRun && (st_next.weekday == MONDAY);
			end
			CEV_MONTH: begin
				calEvt = dateWrap;
			end
			default: begin
				calEvt = monthWrap;
			end
		endcase
		setBits[ST_TIME_EVENT] = timeEvt;
		setBits[ST_CAL_EVENT] = calEvt;

		// acknowledge on the next second boundary, hence within one second
		if (tick && (st_reg.timeUpdateRequest || st_reg.calendarUpdateRequest)
				&& !st_reg.updateGranted) begin
			setBits[ST_UPDATE_ACK] = 1'b1;
			st_next.updateGranted = 1'b1;
		end

		// write channel: address and data are caught in either order
		if (axiReq.awvalid && axiRsp.awready) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && axiRsp.wready) begin
			st_next.wHeld = 1'b1;
			st_next.wData = axiReq.wdata;
			st_next.wStrb = axiReq.wstrb;
		end
		if (st_reg.bValid && axiReq.bready) begin
			st_next.bValid = 1'b0;
		end

		// byte strobes merge into the current readback of the word
		strobeMask = {{8{st_reg.wStrb[3]}}, {8{st_reg.wStrb[2]}},
			{8{st_reg.wStrb[1]}}, {8{st_reg.wStrb[0]}}};
		wrBack = readBack(st_reg, st_reg.awAddr);
		wd = (wrBack[31:0] & ~strobeMask) | (st_reg.wData & strobeMask);
		wrProtected = writeProtectEnable;

		// entry checks on the merged word
		wSec = fromBcd({1'b0, wd[TM_SECONDS_LSB +: 7]});
		wMin = fromBcd({1'b0, wd[TM_MINUTES_LSB +: 7]});
		wHour = fromBcd({2'b00, wd[TM_HOURS_LSB +: 6]});
		if (!st_reg.hourFormatSelect) begin
			wHour24 = wHour;
		end else if (wHour == 7'(HOURS12_MAX)) begin
			wHour24 = wd[TM_MERIDIEM] ? 7'(NOON_HOUR) : 7'd0;
		end else begin
			wHour24 = wd[TM_MERIDIEM] ? wHour + 7'(NOON_HOUR) : wHour;
		end
		timeOk = bcdOk({1'b0, wd[TM_SECONDS_LSB +: 7]}) && (wSec <= 7'(SECONDS_MAX))
			&& bcdOk({1'b0, wd[TM_MINUTES_LSB +: 7]}) && (wMin <= 7'(SECONDS_MAX))
			&& bcdOk({2'b00, wd[TM_HOURS_LSB +: 6]});
		if (st_reg.hourFormatSelect) begin
			timeOk = timeOk && (wHour >= 7'd1) && (wHour <= 7'(HOURS12_MAX));
		end else begin
			timeOk = timeOk && (wHour <= 7'(HOURS24_MAX)) && !wd[TM_MERIDIEM];
		end

		wYear = fromBcd(wd[CD_YEAR_LSB +: 8]);
		wMonth = fromBcd({3'b000, wd[CD_MONTH_LSB +: 5]});
		wDate = fromBcd({2'b00, wd[CD_DATE_LSB +: 6]});
		wWeekday = wd[CD_WEEKDAY_LSB +: 3];
		calOk = ({1'b0, wd[CD_CENTURY_LSB +: 7]} == CENTURY_ONLY_BCD)
			&& bcdOk(wd[CD_YEAR_LSB +: 8]) && (wYear <= YEAR_MAX)
			&& bcdOk({3'b000, wd[CD_MONTH_LSB +: 5]}) && (wMonth >= 7'd1)
			&& (wMonth <= 7'(MONTH_MAX))
			&& bcdOk({2'b00, wd[CD_DATE_LSB +: 6]}) && (wDate >= 7'd1)
			&& (wDate <= 7'(daysIn(wMonth[3:0], wYear)))
			&& (wWeekday >= MONDAY) && (wWeekday <= WEEKDAY_MAX);

		if (st_reg.awHeld && st_reg.wHeld && !st_reg.bValid) begin
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			st_next.bValid = 1'b1;
			st_next.bResp = wrBack[32] ? RESP_OKAY : RESP_SLVERR;
			if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_CLOCK_CONTROL) begin
				if (!wrProtected) begin
					wd = wd & CR_MASK;
					st_next.timeUpdateRequest = wd[CR_TIME_REQ];
					st_next.calendarUpdateRequest = wd[CR_CAL_REQ];
					st_next.timeEventSelect = time_event_sel_e'(wd[CR_TIME_SEL_LSB +: 2]);
					st_next.calendarEventSelect = cal_event_sel_e'(wd[CR_CAL_SEL_LSB +: 2]);
					if (!wd[CR_TIME_REQ] && !wd[CR_CAL_REQ]) begin
						st_next.updateGranted = 1'b0;
					end
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_HOUR_FORMAT_MODE) begin
				if (!wrProtected) begin
					st_next.hourFormatSelect = wd[MR_HOUR_FORMAT];
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_TIME_OF_DAY) begin
				if (st_reg.updateGranted && st_reg.timeUpdateRequest) begin
					if (timeOk) begin
						st_next.seconds = wSec[5:0];
						st_next.minutes = wMin[5:0];
						st_next.hours = wHour24[4:0];
						st_next.validity[VER_TIME] = 1'b0;
					end else begin
						st_next.validity[VER_TIME] = 1'b1;
					end
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_CALENDAR_DATE) begin
				if (st_reg.updateGranted && st_reg.calendarUpdateRequest) begin
					if (calOk) begin
						st_next.year = wYear;
						st_next.month = wMonth[3:0];
						st_next.date = wDate[4:0];
						st_next.weekday = wWeekday;
						st_next.validity[VER_CAL] = 1'b0;
					end else begin
						st_next.validity[VER_CAL] = 1'b1;
					end
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_TIME_ALARM) begin
				if (!wrProtected) begin
					st_next.timeAlarm = wd & TIME_ALARM_MASK;
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_DATE_ALARM) begin
				if (!wrProtected) begin
					st_next.dateAlarm = wd & DATE_ALARM_MASK;
				end
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_STATUS_CLEAR) begin
				clrBits = wd[4:0];
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_IRQ_ENABLE_SET) begin
				st_next.irqMask = st_reg.irqMask | wd[4:0];
			end else if ({st_reg.awAddr[ADDR_W-1:2], 2'b00} == OFF_IRQ_ENABLE_CLEAR) begin
				st_next.irqMask = st_reg.irqMask & ~wd[4:0];
			end
		end

		// a flag raised in the clearing cycle survives the clear
		st_next.status = (st_reg.status & ~clrBits) | setBits;

		// read channel: one outstanding read, data held until taken
		rdBack = readBack(st_reg, axiReq.araddr);
		if (st_reg.rValid && axiReq.rready) begin
			st_next.rValid = 1'b0;
		end
		if (axiReq.arvalid && axiRsp.arready) begin
			st_next.rValid = 1'b1;
			st_next.rData = rdBack[31:0];
			st_next.rResp = rdBack[32] ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.timeEventSelect <= TEV_MINUTE;
			st_reg.calendarEventSelect <= CEV_WEEK;
			st_reg.weekday <= CAL_RESET[CD_WEEKDAY_LSB +: 3];
			st_reg.date <= 5'(fromBcd({2'b00, CAL_RESET[CD_DATE_LSB +: 6]}));
			st_reg.month <= 4'(fromBcd({3'b000, CAL_RESET[CD_MONTH_LSB +: 5]}));
			st_reg.year <= fromBcd(CAL_RESET[CD_YEAR_LSB +: 8]);
			st_reg.dateAlarm <= DATE_ALARM_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule : bcd_calendar_clock_regs
`default_nettype wire

/* File: verif/bcd_calendar_clock_regs_props.sv */
// concurrent checks on the bcd clock register block
// sees only the top ports; bound to every instance below
`timescale 1ns/1ps
`default_nettype none
module bcd_clock_props import bcd_clock_pkg::*; #(
	parameter int unsigned SECOND_CYCLES = 20
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic writeProtectEnable,
	input wire axi_req_s axiReq,
	input wire axi_rsp_s axiRsp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence sRd(logic [5:0] w);
		axiReq.arvalid && axiRsp.arready && axiReq.araddr[7:2] == w;
	endsequence
	sequence sWr;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	a_write_answer: assert property (sWr |=> ##1 axiRsp.bvalid)
		else $error("write not answered");
	a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read not answered");
	a_bresp_holds: assert property (axiRsp.bvalid && !axiReq.bready |=>
		axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (axiRsp.rvalid && !axiReq.rready |=>
		axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read data dropped");
	a_ar_blocked: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("address taken during read answer");
	a_unmapped_zero: assert property (axiReq.arvalid && axiRsp.arready && axiReq.araddr >= 8'h30
		|=> axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	a_ctrl_reserved: assert property (sRd(6'h0) |=> (axiRsp.rdata & ~CR_MASK) == 32'h0)
		else $error("control reserved bits set");
	a_mode_reserved: assert property (sRd(6'h1) |=> axiRsp.rdata[31:1] == 31'h0)
		else $error("mode reserved bits set");
	a_time_format: assert property (sRd(6'h2) |=> axiRsp.rdata[31:22] == 10'h0
		&& axiRsp.rdata[6:4] <= 3'h5 && axiRsp.rdata[3:0] <= 4'h9
		&& axiRsp.rdata[14:12] <= 3'h5 && axiRsp.rdata[11:8] <= 4'h9)
		else $error("time readback out of range");
	a_century_fixed: assert property (sRd(6'h3) |=> axiRsp.rdata[6:0] == 7'h20)
		else $error("century not twenty");
	a_month_range: assert property (sRd(6'h3) |=>
		axiRsp.rdata[20:16] inside {[5'h01:5'h09], [5'h10:5'h12]})
		else $error("month out of range");
endmodule : bcd_clock_props
bind bcd_calendar_clock_regs bcd_clock_props #(.SECOND_CYCLES(SECOND_CYCLES)) i_bcd_clock_props (
	.clk_sys(clk_sys),
	.rst(rst),
	.writeProtectEnable(writeProtectEnable),
	.axiReq(axiReq),
	.axiRsp(axiRsp)
);
`default_nettype wire

/* File: verif/test_bcd_calendar_clock_regs.sv */
// self-checking bench for the bcd clock register block
// drives the axi4-lite port itself; a short second keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module test_bcd_calendar_clock_regs import bcd_clock_pkg::*;;
	localparam int SEC = 20;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] x; logic [3:0] v;} row_s;
	typedef struct packed {logic [31:0] c; logic [31:0] t; logic [31:0] k; logic [1:0] e;} ev_s;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic writeProtectEnable = 1'b0;
	axi_req_s axiReq = '0;
	axi_rsp_s axiRsp;
	logic [31:0] d;
	logic [31:0] t;
	logic [1:0] r;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	// v: bit3 write first, bit2 check validity, bits1:0 expected validity
	// the first seven rows are pure reset reads, reused after the mid-run reset
	row_s baseRows [20] = '{
		'{8'h00, 32'h0, 32'h0, 4'h0}, '{8'h04, 32'h0, 32'h0, 4'h0},
		'{8'h0c, 32'h0, 32'h01210720, 4'h0}, '{8'h10, 32'h0, 32'h0, 4'h0},
		'{8'h14, 32'h0, 32'h01010000, 4'h0}, '{8'h28, 32'h0, 32'h0, 4'h0},
		'{8'h2c, 32'h0, 32'h0, 4'h0}, '{8'h30, 32'hffffffff, 32'h0, 4'h8},
		'{8'hfc, 32'h0, 32'h0, 4'h0}, '{8'h00, 32'hfffffcfc, 32'h00030000, 4'h8},
		'{8'h04, 32'hffffffff, 32'h1, 4'h8}, '{8'h04, 32'h0, 32'h0, 4'h8},
		'{8'h10, 32'hffffffff, 32'h00ffffff, 4'h8}, '{8'h14, 32'hffffffff, 32'hbf9f0000, 4'h8},
		'{8'h28, 32'hffffffff, 32'h0, 4'h8}, '{8'h00, 32'h0, 32'h0, 4'h8},
		'{8'h20, 32'hffffffff, 32'h0, 4'h8}, '{8'h28, 32'h0, 32'h1f, 4'h0},
		'{8'h24, 32'h00000005, 32'h0, 4'h8}, '{8'h28, 32'h0, 32'h1a, 4'h0}};
	// only the time request is granted when this table starts
	row_s updRows [15] = '{
		'{8'h0c, 32'h15662420, 32'h01210720, 4'hc},
		'{8'h04, 32'h1, 32'h1, 4'h8},
		'{8'h08, 32'h00434530, 32'h00154530, 4'hc},
		'{8'h08, 32'h00034560, 32'h00154530, 4'hd},
		'{8'h08, 32'h00130000, 32'h00154530, 4'hd},
		'{8'h08, 32'h00120000, 32'h0, 4'hc},
		'{8'h04, 32'h0, 32'h0, 4'h8}, '{8'h08, 32'h00240000, 32'h0, 4'hd},
		'{8'h08, 32'h00400000, 32'h0, 4'hd},
		'{8'h08, 32'h00235959, 32'h00235959, 4'hc}, '{8'h00, 32'h3, 32'h3, 4'h8},
		'{8'h0c, 32'h15662420, 32'h15662420, 4'hc},
		'{8'h0c, 32'h15662419, 32'h15662420, 4'he},
		'{8'h0c, 32'h15732420, 32'h15662420, 4'he},
		'{8'h0c, 32'h15669a20, 32'h15662420, 4'he}};
	// control, start time, start date, expected calendar and time event bits
	ev_s evRows [10] = '{
		'{32'h0, 32'h59, 32'h14e62420, 2'b01}, '{32'h100, 32'h5959, 32'h14e62420, 2'b01},
		'{32'h200, 32'h235959, 32'h14e62420, 2'b11}, '{32'h300, 32'h115959, 32'h14e62420, 2'b01},
		'{32'h10200, 32'h235959, 32'h14e62420, 2'b01}, '{32'h10200, 32'h235959, 32'h30662420, 2'b11},
		'{32'h20200, 32'h235959, 32'h30662420, 2'b01}, '{32'h20200, 32'h235959, 32'h31722420, 2'b11},
		'{32'h0, 32'h235959, 32'h30662420, 2'b01}, '{32'h300, 32'h235959, 32'h30662420, 2'b00}};

	always #2 clk_sys = ~clk_sys;

	bcd_calendar_clock_regs #(.SECOND_CYCLES(SEC)) i_bcd_calendar_clock_regs (
		.clk_sys(clk_sys),
		.rst(rst),
		.writeProtectEnable(writeProtectEnable),
		.axiReq(axiReq),
		.axiRsp(axiRsp)
	);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// a hang anywhere lands here as a mismatch
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		logic aw = 1'b0;
		logic wd = 1'b0;
		@(posedge clk_sys);
		axiReq.awaddr <= a;
		axiReq.wdata <= w;
		axiReq.wstrb <= 4'hf;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
			aw |= axiRsp.awready;
			wd |= axiRsp.wready;
		end while (!(aw && wd));
		do @(posedge clk_sys); while (axiRsp.bvalid !== 1'b1);
		axiReq.bready <= 1'b0;
		r = axiRsp.bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do @(posedge clk_sys); while (axiRsp.arready !== 1'b1);
		axiReq.arvalid <= 1'b0;
		do @(posedge clk_sys); while (axiRsp.rvalid !== 1'b1);
		axiReq.rready <= 1'b0;
		d = axiRsp.rdata;
		r = axiRsp.rresp;
	endtask : rd

	task automatic doRow(input row_s q);
		logic [31:0] e;
		e = q.a >= 8'h30 ? 32'(RESP_SLVERR) : 32'(RESP_OKAY);
		if (q.v[3]) begin
			wr(q.a, q.w);
			chk(32'(r), e);
		end
		rd(q.a);
		chk(d, q.x);
		chk(32'(r), e);
		if (q.v[2]) begin
			rd(OFF_ENTRY_VALIDITY);
			chk(d, 32'(q.v[1:0]));
		end
	endtask : doRow

	// ack may take up to one second; bound allows a poll beyond it
	task automatic grant(input logic [31:0] c);
		int k;
		k = 0;
		wr(OFF_CLOCK_CONTROL, c);
		do begin
			rd(OFF_EVENT_STATUS);
			k++;
		end while (d[0] !== 1'b1 && k < 12);
		chk(32'(k < 9), 32'h1);
	endtask : grant

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (baseRows[i]) doRow(baseRows[i]);
		$display("test register map done");
		writeProtectEnable <= 1'b1;
		wr(OFF_HOUR_FORMAT_MODE, 32'h1);
		wr(OFF_CLOCK_CONTROL, 32'h3);
		rd(OFF_HOUR_FORMAT_MODE);
		chk(d, 32'h0);
		rd(OFF_CLOCK_CONTROL);
		chk(d, 32'h0);
		writeProtectEnable <= 1'b0;
		$display("test protection done");
		grant(32'h1);
		foreach (updRows[i]) doRow(updRows[i]);
		repeat (2 * SEC) @(posedge clk_sys);
		rd(OFF_TIME_OF_DAY);
		chk(d, 32'h00235959);
		rd(OFF_CALENDAR_DATE);
		chk(d, 32'h15662420);
		wr(OFF_CLOCK_CONTROL, 32'h2);
		rd(OFF_TIME_OF_DAY);
		t = d;
		repeat (SEC + 4) @(posedge clk_sys);
		rd(OFF_TIME_OF_DAY);
		chk(32'(d !== t), 32'h1);
		$display("test update entry done");
		foreach (evRows[i]) begin
			grant(evRows[i].c | 32'h3);
			wr(OFF_TIME_OF_DAY, evRows[i].t);
			wr(OFF_CALENDAR_DATE, evRows[i].k);
			wr(OFF_STATUS_CLEAR, 32'h1f);
			wr(OFF_CLOCK_CONTROL, evRows[i].c);
			n = 0;
			do begin
				rd(OFF_TIME_OF_DAY);
				n++;
			end while (d === evRows[i].t && n < 12);
			rd(OFF_EVENT_STATUS);
			chk(32'(d[4:3]), 32'(evRows[i].e));
		end
		$display("test events done");
		// mid-run reset with the bus idle; the seven registers read at start must show their reset values again
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) doRow(baseRows[i]);
		$display("test reset done");
		end_of_test();
	end
endmodule : test_bcd_calendar_clock_regs
`default_nettype wire
